// ==== design/scpmc_top.sv ====
// Purpose: system clock choice and power operating mode control
// Assumes: halt_req and wake_req come from core logic on ref_clk
// Notes:   all clocks leave as one-cycle enables on ref_clk
//
// Summary of operation
// R01 - System clock is fast or slow, chosen by the select bit and divide field.
// R02 - Fast clock source is crystal, external RC or internal RC, by strap.
// R03 - Divided fast clocks from 4 to 64 are offered as system clock.
// R04 - Switching to the slow clock stops the fast oscillator.
// R05 - Substitute and time-base clocks come from the slow internal RC.
// R06 - After wake-up the core may run from the substitute clock.
// R07 - Watchdog clock is the substitute clock or system clock over 4.
// R08 - Time-base clock feeds time-base interrupts and timer modules.
// R09 - Six modes: two running, four with the core stopped.
// R10 - Full speed runs from the fast oscillator divided 1 to 64.
// R11 - Slow run uses the slow RC with the fast clock off.
// R12 - Halt with idle enable low enters a sleep mode.
// R13 - Deep sleep stops core, substitute and watchdog clocks.
// R14 - Deep sleep is never entered while low voltage detect is enabled.
// R15 - Light sleep keeps substitute and watchdog clocks for LVD or watchdog.
// R16 - Halt with idle enable high and keep-on low enters idle clock off.
// R17 - Idle clock off stops the system oscillator and core clock.
// R18 - Idle clock off keeps timer clocks going, and the watchdog clock when taken from substitute.
// R19 - Idle clock off: watchdog clock off from system, on from substitute.
// R20 - Halt with idle enable and keep-on high keeps system clock running.
// R21 - Divide codes 000,001 pick slow; 010..110 pick fast over 64..4.
// R22 - Select bit high gives the undivided fast clock.
// R23 - Wake-up returns to the running mode and clock that were set.
//
// Decided for this implementation: register access over Avalon-MM and the register offsets.
`timescale 1ns/10ps
`include "scpmc_regs.svh"
module scpmc_top #(
  parameter int WAKE_FAST_TICKS = `SCPMC_WARM_TICKS  // Fast osc restart ticks
) (
  input  wire logic                       ref_clk,         // 40 MHz clock
  input  wire logic                       rst,             // Sync reset
  input  wire logic [3:0]                 avs_address,     // Byte address
  input  wire logic                       avs_read,        // Read strobe
  input  wire logic                       avs_write,       // Write strobe
  input  wire logic [31:0]                avs_writedata,   // Write data
  output logic      [31:0]                avs_readdata,    // Read data
  output logic                            avs_waitrequest, // Stall
  input  wire scpmc_pkg::scpmc_fast_src_e fast_src_strap,  // Fast osc option
  input  wire logic                       halt_req,        // Halt executed
  input  wire logic                       wake_req,        // Wake event
  output logic                            cpu_clk_en,      // Core clock pulse
  output logic                            sys_clk_en,      // System clock pulse
  output logic                            sub_clk_en,      // Substitute pulse
  output logic                            wdt_clk_en,      // Watchdog pulse
  output logic                            tbc_clk_en,      // Time-base pulse
  output logic                            fast_osc_on,     // Fast osc running
  output logic                            slow_osc_on,     // Slow osc running
  output scpmc_pkg::scpmc_mode_e          op_mode          // Current mode
);
  import scpmc_pkg::*;
  localparam logic [2:0] CKS_SLOW_MAX = `SCPMC_CKS_SLOW_MAX;

  scpmc_cfg_if cfg ();

  logic        fast_tick;
  logic        slow_tick;
  scpmc_mode_e next_mode;
  logic [5:0]  div_cnt;
  logic [1:0]  wdt_div;
  logic [15:0] warm_cnt;
  logic        warm_sub;
  logic        run_fast;
  scpmc_mode_e run_mode;
  logic        fdiv_tick;
  logic        sel_tick;
  logic        sys_tick;
  logic        cpu_tick;
  logic        warm_done;

  // ***************************************************
  // Helpers
  // ***************************************************
  function automatic logic [5:0] div_mask(input logic [2:0] cks);
    case (cks)
      3'h2:    div_mask = 6'h3f;
      3'h3:    div_mask = 6'h1f;
      3'h4:    div_mask = 6'h0f;
      3'h5:    div_mask = 6'h07;
      default: div_mask = 6'h03;
    endcase
  endfunction

  function automatic scpmc_mode_e halt_target(input logic idle_en, input logic keep_on,
                                              input logic lvd_en, input logic wdt_en,
                                              input logic wdt_sub);
    if (idle_en)
      halt_target = keep_on ? MODE_IDLE_ON : MODE_IDLE_OFF;
    else if (lvd_en || (wdt_en && wdt_sub))
      halt_target = MODE_LIGHT;
    else
      halt_target = MODE_DEEP;
  endfunction

  function automatic logic fast_need(input scpmc_mode_e m, input logic rf);
    fast_need = (m == MODE_FULL) || (m == MODE_WARM) || ((m == MODE_IDLE_ON) && rf);
  endfunction

  // ***************************************************
  // Submodules
  // ***************************************************
  scpmc_avmm u_avmm (
    .ref_clk         (ref_clk),
    .rst             (rst),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .cfg             (cfg.regs)
  );

  scpmc_clkgen u_clkgen (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .src_pin   (fast_src_strap),
    .fast_run  (fast_osc_on),
    .slow_run  (slow_osc_on),
    .fast_tick (fast_tick),
    .slow_tick (slow_tick)
  );

  assign cfg.mode    = op_mode;
  assign cfg.fast_on = fast_osc_on;

  // ***************************************************
  // System clock selection
  // ***************************************************
  assign run_fast = cfg.high_low_clock_select || (cfg.cks > CKS_SLOW_MAX);                 // [R01] [R22]
  assign run_mode = run_fast ? MODE_FULL : MODE_SLOW;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      div_cnt <= 6'h00;
    else if (fast_tick)
      div_cnt <= div_cnt + 6'h01;
  end

  assign fdiv_tick = fast_tick && ((div_cnt & div_mask(cfg.cks)) == div_mask(cfg.cks)); // [R03] [R21]

  always_comb
  begin
    if (cfg.high_low_clock_select)
      sel_tick = fast_tick;                                                 // [R22] [R10]
    else if (cfg.cks <= CKS_SLOW_MAX)
      sel_tick = slow_tick;                                                 // [R21] [R11]
    else
      sel_tick = fdiv_tick;                                                 // [R10]
  end

  always_comb
  begin
    case (op_mode)
      MODE_FULL, MODE_SLOW:
      begin
        sys_tick = sel_tick;
        cpu_tick = sel_tick;
      end
      MODE_IDLE_ON:
      begin
        sys_tick = sel_tick;                                                // [R20]
        cpu_tick = 1'b0;
      end
      MODE_WARM:
      begin
        sys_tick = warm_sub && slow_tick;                                   // [R06]
        cpu_tick = warm_sub && slow_tick;
      end
      default:
      begin
        sys_tick = 1'b0;                                                    // [R13] [R17]
        cpu_tick = 1'b0;
      end
    endcase
  end

  // ***************************************************
  // Mode sequencing
  // ***************************************************
  assign warm_done = fast_tick && (warm_cnt == 16'(WAKE_FAST_TICKS - 1));

  always_comb
  begin
    case (op_mode)
      MODE_FULL, MODE_SLOW:
        if (halt_req)
          next_mode = halt_target(cfg.idle_en, cfg.keep_on, cfg.lvd_en,
                                  cfg.wdt_en, cfg.wdt_sub);                 // [R12] [R14] [R16] [R20]
        else
          next_mode = run_mode;                                             // [R04] [R09]
      MODE_DEEP, MODE_LIGHT, MODE_IDLE_OFF:
        if (wake_req)
          next_mode = run_fast ? MODE_WARM : MODE_SLOW;                     // [R23]
        else
          next_mode = op_mode;
      MODE_IDLE_ON:
        next_mode = wake_req ? run_mode : MODE_IDLE_ON;                     // [R23]
      MODE_WARM:
        if (!run_fast || warm_done)
          next_mode = run_mode;                                             // [R23]
        else
          next_mode = MODE_WARM;
      default:
        next_mode = MODE_FULL;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      op_mode <= MODE_FULL;
    else
      op_mode <= next_mode;                                                 // [R09]
  end

  // Substitute clock only helps if it survived the sleep
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      warm_sub <= 1'b0;
    else if (next_mode == MODE_WARM && op_mode != MODE_WARM)
      warm_sub <= cfg.fast_wake && (op_mode != MODE_DEEP);                  // [R06]
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst || op_mode != MODE_WARM)
      warm_cnt <= 16'h0000;
    else if (fast_tick)
      warm_cnt <= warm_cnt + 16'h0001;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      fast_osc_on <= 1'b1;
      slow_osc_on <= 1'b1;
    end
    else
    begin
      fast_osc_on <= fast_need(next_mode, run_fast);                       // [R04] [R11] [R17]
      slow_osc_on <= (next_mode != MODE_DEEP);                              // [R05] [R13]
    end
  end

  // ***************************************************
  // Peripheral clock enables
  // ***************************************************
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      wdt_div <= 2'h0;
    else if (sys_tick)
      wdt_div <= wdt_div + 2'h1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cpu_clk_en <= 1'b0;
      sys_clk_en <= 1'b0;
      sub_clk_en <= 1'b0;
      wdt_clk_en <= 1'b0;
      tbc_clk_en <= 1'b0;
    end
    else
    begin
      cpu_clk_en <= cpu_tick;
      sys_clk_en <= sys_tick;
      sub_clk_en <= slow_tick && (op_mode != MODE_DEEP);                    // [R05] [R15]
      if (cfg.wdt_sub)
        wdt_clk_en <= slow_tick && (op_mode != MODE_DEEP);                  // [R07] [R19]
      else
        wdt_clk_en <= sys_tick && (wdt_div == 2'h3);                        // [R07] [R19]
      tbc_clk_en <= slow_tick && (op_mode != MODE_DEEP) && (op_mode != MODE_LIGHT); // [R08] [R18]
    end
  end

  // ***************************************************
  // Assertions
  // ***************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_halt_run;
    (op_mode == MODE_FULL || op_mode == MODE_SLOW) && halt_req;
  endsequence

  sequence s_in_sleep;
    (op_mode == MODE_LIGHT || op_mode == MODE_IDLE_OFF) && !wake_req;
  endsequence

  property p_halt_sleep;
    s_halt_run ##0 !cfg.idle_en |=> (op_mode == MODE_DEEP || op_mode == MODE_LIGHT);
  endproperty
  a_halt_sleep: assert property (p_halt_sleep) else $error("halt did not sleep"); // [R12]

  property p_lvd_no_deep;
    s_halt_run ##0 cfg.lvd_en |=> op_mode != MODE_DEEP;
  endproperty
  a_lvd_no_deep: assert property (p_lvd_no_deep) else $error("deep sleep with lvd on"); // [R14]

  property p_idle_off;
    s_halt_run ##0 (cfg.idle_en && !cfg.keep_on) |=> op_mode == MODE_IDLE_OFF ##1 !fast_osc_on;
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("idle off not entered"); // [R16]

  property p_idle_on;
    s_halt_run ##0 (cfg.idle_en && cfg.keep_on) |=> op_mode == MODE_IDLE_ON ##1 !cpu_clk_en;
  endproperty
  a_idle_on: assert property (p_idle_on) else $error("idle on not entered"); // [R20]

  property p_deep_quiet;
    op_mode == MODE_DEEP |=> !sub_clk_en && !wdt_clk_en && !cpu_clk_en && !tbc_clk_en;
  endproperty
  a_deep_quiet: assert property (p_deep_quiet) else $error("clock alive in deep sleep"); // [R13]

  property p_slow_fast_off;
    op_mode == MODE_SLOW ##1 op_mode == MODE_SLOW |-> !fast_osc_on && !fast_tick;
  endproperty
  a_slow_fast_off: assert property (p_slow_fast_off) else $error("fast osc on in slow run"); // [R11]

  property p_direct_fast;
    op_mode == MODE_FULL && cfg.high_low_clock_select && fast_tick |=> sys_clk_en && cpu_clk_en;
  endproperty
  a_direct_fast: assert property (p_direct_fast) else $error("undivided fast clock missing"); // [R22]

  property p_div64_gap;
    op_mode == MODE_FULL && !cfg.high_low_clock_select && cfg.cks == 3'h2 && div_cnt != 6'h3f |=> !sys_clk_en;
  endproperty
  a_div64_gap: assert property (p_div64_gap) else $error("fast over 64 ticked early"); // [R21]

  property p_idle_off_wdt;
    op_mode == MODE_IDLE_OFF && !cfg.wdt_sub |=> !wdt_clk_en;
  endproperty
  a_idle_off_wdt: assert property (p_idle_off_wdt) else $error("watchdog clock on in idle off"); // [R19]

  property p_sleep_sub;
    s_in_sleep ##0 slow_tick |=> sub_clk_en;
  endproperty
  a_sleep_sub: assert property (p_sleep_sub) else $error("substitute clock stopped"); // [R15]

  property p_idle_off_tbc;
    op_mode == MODE_IDLE_OFF && slow_tick |=> tbc_clk_en;
  endproperty
  a_idle_off_tbc: assert property (p_idle_off_tbc) else $error("time base stopped in idle off"); // [R18]

  property p_wake_resume;
    op_mode == MODE_IDLE_ON && wake_req |=> op_mode == $past(run_mode);
  endproperty
  a_wake_resume: assert property (p_wake_resume) else $error("wake did not resume run mode"); // [R23]

  property p_warm_sub;
    op_mode == MODE_WARM && warm_sub && slow_tick |=> cpu_clk_en;
  endproperty
  a_warm_sub: assert property (p_warm_sub) else $error("core not on substitute clock"); // [R06]
endmodule

// ==== inc/scpmc_regs.svh ====
// Purpose: register offsets, field positions, reset values, timing
// Assumes: ref_clk at 40 MHz
// Notes:   definitions only
`ifndef SCPMC_REGS_SVH
`define SCPMC_REGS_SVH
`define SCPMC_ADDR_MODE     4'h0
`define SCPMC_ADDR_PWR      4'h4
`define SCPMC_ADDR_LVD      4'h8
`define SCPMC_ADDR_STAT     4'hc
`define SCPMC_HIGH_LOW_CLOCK_SELECT_BIT     0
`define SCPMC_IDLE_MODE_ENABLE_BIT     1
`define SCPMC_FSTEN_BIT     4
`define SCPMC_CKS_LSB       5
`define SCPMC_KEEP_BIT      0
`define SCPMC_WDTEN_BIT     1
`define SCPMC_WDTSUB_BIT    2
`define SCPMC_LOW_VOLTAGE_DETECT_ENABLE_BIT     0
`define SCPMC_STAT_FAST_BIT 4
`define SCPMC_MODE_RST      8'h03
`define SCPMC_MODE_WMASK    8'hf3
`define SCPMC_PWR_RST       8'h00
`define SCPMC_LVD_RST       1'h0
`define SCPMC_CKS_SLOW_MAX  3'h1
`define SCPMC_REF_NS        25
`define SCPMC_XTAL_NS       250
`define SCPMC_ERC_NS        125
`define SCPMC_INTERNAL_FAST_RC_NS       125
`define SCPMC_INTERNAL_SLOW_RC_NS       31250
`define SCPMC_WARM_TICKS    1024
`endif

// ==== inc/scpmc_pkg.sv ====
// Purpose: shared types of the clock and power mode block
// Assumes: nothing
// Notes:   mode codes also show in the status register
package scpmc_pkg;
  typedef enum logic [2:0] {
    MODE_FULL     = 3'b000,
    MODE_SLOW     = 3'b001,
    MODE_DEEP     = 3'b010,
    MODE_LIGHT    = 3'b011,
    MODE_IDLE_OFF = 3'b100,
    MODE_IDLE_ON  = 3'b101,
    MODE_WARM     = 3'b110
  } scpmc_mode_e;
  typedef enum logic [1:0] {
    SRC_CRYSTAL  = 2'b00,
    SRC_EXT_RC   = 2'b01,
    SRC_INT_FAST = 2'b10
  } scpmc_fast_src_e;
endpackage

// ==== inc/scpmc_cfg_if.sv ====
// Purpose: configuration and status between register file and core
// Assumes: single ref_clk domain
// Notes:   none
`timescale 1ns/10ps
interface scpmc_cfg_if;
  import scpmc_pkg::*;
  logic        high_low_clock_select;
  logic [2:0]  cks;
  logic        fast_wake;
  logic        idle_en;
  logic        keep_on;
  logic        wdt_en;
  logic        wdt_sub;
  logic        lvd_en;
  scpmc_mode_e mode;
  logic        fast_on;
  modport regs (output high_low_clock_select, cks, fast_wake, idle_en, keep_on, wdt_en, wdt_sub, lvd_en,
                input mode, fast_on);
  modport core (input high_low_clock_select, cks, fast_wake, idle_en, keep_on, wdt_en, wdt_sub, lvd_en,
                output mode, fast_on);
endinterface

// ==== design/scpmc_clkgen.sv ====
// Purpose: oscillator tick generation on ref_clk
// Assumes: fast source strap is static after reset
// Notes:   each oscillator is an enable pulse, stopped when not run
`timescale 1ns/10ps
`include "scpmc_regs.svh"
module scpmc_clkgen (
  input  wire logic                       ref_clk,   // System clock
  input  wire logic                       rst,       // Sync reset
  input  wire scpmc_pkg::scpmc_fast_src_e src_pin,   // Fast source strap
  input  wire logic                       fast_run,  // Fast osc enable
  input  wire logic                       slow_run,  // Slow osc enable
  output logic                            fast_tick, // Fast osc pulse
  output logic                            slow_tick  // Slow osc pulse
);
  import scpmc_pkg::*;
  localparam logic [3:0]  XTAL_LIM = 4'(`SCPMC_XTAL_NS / `SCPMC_REF_NS - 1);
  localparam logic [3:0]  ERC_LIM  = 4'(`SCPMC_ERC_NS / `SCPMC_REF_NS - 1);
  localparam logic [3:0]  INTERNAL_FAST_RC_LIM = 4'(`SCPMC_INTERNAL_FAST_RC_NS / `SCPMC_REF_NS - 1);
  localparam logic [10:0] SLOW_LIM = 11'(`SCPMC_INTERNAL_SLOW_RC_NS / `SCPMC_REF_NS - 1);
  logic [1:0]  src_s1;
  logic [1:0]  src_s2;
  logic [1:0]  src_cap;
  logic        cap_done;
  logic [3:0]  fast_lim;
  logic [3:0]  fast_cnt;
  logic [10:0] slow_cnt;
  // Source is a configuration option, caught once after reset [R02]
  always_ff @(posedge ref_clk)
  begin
    src_s1 <= src_pin;
    src_s2 <= src_s1;
    if (rst)
    begin
      cap_done <= 1'b0;
      src_cap  <= SRC_CRYSTAL;
    end
    else if (!cap_done)
    begin
      cap_done <= 1'b1;
      src_cap  <= src_s2;
    end
  end
  always_comb
  begin
    case (src_cap)
      SRC_EXT_RC:   fast_lim = ERC_LIM;
      SRC_INT_FAST: fast_lim = INTERNAL_FAST_RC_LIM;
      default:      fast_lim = XTAL_LIM;
    endcase
  end
  always_ff @(posedge ref_clk)
  begin
    if (rst || !fast_run || !cap_done)
    begin
      fast_cnt  <= 4'h0;
      fast_tick <= 1'b0;
    end
    else
    begin
      fast_tick <= (fast_cnt == fast_lim);
      fast_cnt  <= (fast_cnt == fast_lim) ? 4'h0 : fast_cnt + 4'h1;
    end
  end
  always_ff @(posedge ref_clk)
  begin
    if (rst || !slow_run)
    begin
      slow_cnt  <= 11'h000;
      slow_tick <= 1'b0;
    end
    else
    begin
      slow_tick <= (slow_cnt == SLOW_LIM);
      slow_cnt  <= (slow_cnt == SLOW_LIM) ? 11'h000 : slow_cnt + 11'h001;
    end
  end
endmodule

// ==== design/scpmc_avmm.sv ====
// Purpose: Avalon-MM register file for mode and power control
// Assumes: one word per register, byte addresses
// Notes:   every access answers one cycle after it is seen
`timescale 1ns/10ps
`include "scpmc_regs.svh"
module scpmc_avmm (
  input  wire logic        ref_clk,         // System clock
  input  wire logic        rst,             // Sync reset
  input  wire logic [3:0]  avs_address,     // Byte address
  input  wire logic        avs_read,        // Read strobe
  input  wire logic        avs_write,       // Write strobe
  input  wire logic [31:0] avs_writedata,   // Write data
  output logic      [31:0] avs_readdata,    // Read data
  output logic             avs_waitrequest, // Stall
  scpmc_cfg_if.regs        cfg              // Config out, status in
);
  import scpmc_pkg::*;
  logic [7:0]  mode_reg;
  logic [7:0]  pwr_reg;
  logic        lvd_reg;
  logic [31:0] rd_val;
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
  end
  // Write lands on the edge where waitrequest is seen low
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      mode_reg <= `SCPMC_MODE_RST;
      pwr_reg  <= `SCPMC_PWR_RST;
      lvd_reg  <= `SCPMC_LVD_RST;
    end
    else if (avs_write && !avs_waitrequest)
    begin
      case (avs_address)
        `SCPMC_ADDR_MODE: mode_reg <= avs_writedata[7:0] & `SCPMC_MODE_WMASK;
        `SCPMC_ADDR_PWR:  pwr_reg  <= avs_writedata[7:0];
        `SCPMC_ADDR_LVD:  lvd_reg  <= avs_writedata[`SCPMC_LOW_VOLTAGE_DETECT_ENABLE_BIT];
        default:          lvd_reg  <= lvd_reg;
      endcase
    end
  end
  always_comb
  begin
    case (avs_address)
      `SCPMC_ADDR_MODE: rd_val = {24'h000000, mode_reg};
      `SCPMC_ADDR_PWR:  rd_val = {24'h000000, pwr_reg};
      `SCPMC_ADDR_LVD:  rd_val = {31'h00000000, lvd_reg};
      `SCPMC_ADDR_STAT: rd_val = {27'h0000000, cfg.fast_on, 1'b0, cfg.mode};
      default:          rd_val = 32'h00000000;
    endcase
  end
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      avs_readdata <= 32'h00000000;
    else if (avs_read && avs_waitrequest)
      avs_readdata <= rd_val;
  end
  assign cfg.high_low_clock_select     = mode_reg[`SCPMC_HIGH_LOW_CLOCK_SELECT_BIT];
  assign cfg.idle_en   = mode_reg[`SCPMC_IDLE_MODE_ENABLE_BIT];
  assign cfg.fast_wake = mode_reg[`SCPMC_FSTEN_BIT];
  assign cfg.cks       = mode_reg[`SCPMC_CKS_LSB +: 3];
  assign cfg.keep_on   = pwr_reg[`SCPMC_KEEP_BIT];
  assign cfg.wdt_en    = pwr_reg[`SCPMC_WDTEN_BIT];
  assign cfg.wdt_sub   = pwr_reg[`SCPMC_WDTSUB_BIT];
  assign cfg.lvd_en    = lvd_reg;
endmodule

// ==== verif/scpmc_core_model.sv ====
// Purpose: core side that issues halt and wake pulses
// Assumes: same ref_clk as the block
// Notes:   gap sets how promptly a pulse follows the call
`timescale 1ns/10ps
module scpmc_core_model (
  input  wire logic ref_clk,  // System clock
  output logic      halt_req, // Halt pulse
  output logic      wake_req  // Wake pulse
);
  initial
  begin
    halt_req = 1'b0;
    wake_req = 1'b0;
  end
  task automatic halt(input int gap);
    repeat (gap) @(posedge ref_clk);
    halt_req <= 1'b1;
    @(posedge ref_clk);
    halt_req <= 1'b0;
  endtask
  task automatic wake(input int gap);
    repeat (gap) @(posedge ref_clk);
    wake_req <= 1'b1;
    @(posedge ref_clk);
    wake_req <= 1'b0;
  endtask
endmodule

// ==== verif/system_clock_power_mode_control_tb.sv ====
// Purpose: self-checking bench for clock choice and power modes
// Assumes: internal fast RC strap first, crystal after the second reset
// Notes:   reads checked from a queue at the answer edge
`timescale 1ns/10ps
module system_clock_power_mode_control_tb;
  import scpmc_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest, halt_req, wake_req, cpu_clk_en, sys_clk_en, fast_osc_on;
  logic        sub_clk_en, slow_osc_on;
  scpmc_mode_e op_mode;
  scpmc_fast_src_e strap = SRC_INT_FAST;
  int          err_total = 0, checked = 0, n, m, p, k;
  logic [31:0] exp_q[$];
  // Halt setup {idle, keep, lvd, wdt_en, wdt_sub}
  logic [4:0]  cfg_t[6] = '{5'h18, 5'h10, 5'h04, 5'h03, 5'h02, 5'h00};
  scpmc_mode_e mode_t[6] = '{MODE_IDLE_ON, MODE_IDLE_OFF, MODE_LIGHT, MODE_LIGHT, MODE_DEEP, MODE_DEEP};
  always #12.5 ref_clk = ~ref_clk;
  scpmc_top #(.WAKE_FAST_TICKS(300)) dut_u (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .fast_src_strap(strap), .halt_req(halt_req),
    .wake_req(wake_req), .cpu_clk_en(cpu_clk_en), .sys_clk_en(sys_clk_en), .sub_clk_en(sub_clk_en),
    .wdt_clk_en(), .tbc_clk_en(), .fast_osc_on(fast_osc_on), .slow_osc_on(slow_osc_on), .op_mode(op_mode));
  scpmc_core_model core_u (.ref_clk(ref_clk), .halt_req(halt_req), .wake_req(wake_req));
  // ****************
  // Checking
  // ****************
  task automatic summarize;
    if (err_total == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Read data taken at the edge where waitrequest is seen low
  always @(posedge ref_clk)
    if (avs_read && avs_waitrequest === 1'b0)
      chk(avs_readdata, exp_q.pop_front());
  // ****************
  // Drivers
  // ****************
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d, input logic [31:0] e);
    int i;
    @(posedge ref_clk);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= ~wr;
    avs_writedata <= {24'($urandom), d};
    if (!wr)
      exp_q.push_back(e);
    i = 0;
    do
    begin
      @(posedge ref_clk);
      i++;
    end
    while (avs_waitrequest !== 1'b0 && i < 50);
    if (avs_waitrequest !== 1'b0)
    begin
      err_total++;
      summarize();
    end
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic cnt(input int cyc, output int cs, output int cc, output int cb);
    cs = 0;
    cc = 0;
    cb = 0;
    repeat (cyc)
    begin
      @(negedge ref_clk);
      cs += int'(sys_clk_en === 1'b1);
      cc += int'(cpu_clk_en === 1'b1);
      cb += int'(sub_clk_en === 1'b1);
    end
  endtask
  task automatic wait_mode(input scpmc_mode_e md);
    int i;
    for (i = 0; i < 3000 && op_mode !== md; i++)
      @(negedge ref_clk);
    chk(32'(op_mode), 32'(md));
    if (op_mode !== md)
      summarize();
  endtask
  // ****************
  // Scenarios
  // ****************
  initial
  begin
    void'($urandom(32'h0325b691));
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    bus(1'b0, 4'h0, 8'h00, 32'h03);
    bus(1'b0, 4'hc, 8'h00, 32'h10);
    bus(1'b1, 4'h0, 8'hff, 32'h0);
    bus(1'b0, 4'h0, 8'h00, 32'hf3);
    bus(1'b1, 4'h2, 8'h5a, 32'h0);
    bus(1'b0, 4'h2, 8'h00, 32'h0);
    for (k = 2; k < 7; k++)
    begin
      bus(1'b1, 4'h0, {k[2:0], 5'h00}, 32'h0);
      cnt(320, n, m, p);
      cnt(640, n, m, p);
      chk(32'(n), 32'(640 / (5 * (256 >> k))));
    end
    bus(1'b1, 4'h0, 8'h20, 32'h0);
    wait_mode(MODE_SLOW);
    chk(32'(fast_osc_on), 32'h0);
    bus(1'b1, 4'h0, 8'h03, 32'h0);
    wait_mode(MODE_FULL);
    for (k = 0; k < 6; k++)
    begin
      bus(1'b1, 4'h0, {3'h0, 1'b1, 2'h0, cfg_t[k][4], 1'b1}, 32'h0);
      bus(1'b1, 4'h4, {5'h00, cfg_t[k][0], cfg_t[k][1], cfg_t[k][3]}, 32'h0);
      bus(1'b1, 4'h8, {7'h00, cfg_t[k][2]}, 32'h0);
      core_u.halt($urandom_range(1, 3));
      @(negedge ref_clk);
      chk(32'(op_mode), 32'(mode_t[k]));
      cnt(4, n, m, p);
      cnt(1250, n, m, p);
      chk(32'(n), (k == 0) ? 32'd250 : 32'd0);
      chk(32'(m), 32'h0);
      chk(32'(p), (k < 4) ? 32'd1 : 32'd0);
      chk(32'(slow_osc_on), 32'(k < 4));
      core_u.wake($urandom_range(1, 3));
      wait_mode(MODE_FULL);
    end
    // Second reset with the crystal option: undivided fast tick every 10 cycles
    @(posedge ref_clk);
    strap <= SRC_CRYSTAL;
    rst   <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    bus(1'b0, 4'hc, 8'h00, 32'h10);
    cnt(320, n, m, p);
    cnt(640, n, m, p);
    chk(32'(n), 32'd64);
    summarize();
  end
  // Hang guard
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    err_total++;
    summarize();
  end
endmodule
